// ===== src/card_select_pkg.sv
// Package with register map, field layout and shared types of the card select block.
package card_select_pkg;
    localparam logic [15:0] interface_select_reg_addr = 16'hfe00;
    localparam logic [15:0] irq_cause_reg_addr = 16'hfe01;
    localparam logic [15:0] irq_enable_reg_addr = 16'hfe02;
    localparam logic [15:0] internal_line_ctl_addr = 16'hfe10;
    localparam logic [15:0] external_line_ctl_addr = 16'hfe11;
    localparam logic [15:0] length_count_addr = 16'hfe12;
    localparam logic [15:0] status_addr = 16'hfe13;
    localparam logic [7:0] interface_select_reset = 8'h00;
    localparam logic [7:0] irq_cause_reset = 8'h00;
    localparam logic [7:0] irq_enable_reset = 8'h00;
    localparam logic [7:0] line_ctl_reset = 8'h00;
    localparam logic [7:0] length_reset = 8'h00;
    localparam logic [7:0] interface_select_mask = 8'h0e;
    localparam int choice_lsb = 2;
    localparam int bypass_bit = 1;
    localparam int line_data_bit = 0;
    localparam int line_dir_bit = 1;
    localparam int line_sample_bit = 5;
    localparam int cause_length = 7;
    localparam int cause_card_event = 6;
    localparam int cause_supply_timer = 5;
    localparam int cause_rx_available = 4;
    localparam int cause_tx_event = 3;
    localparam int cause_tx_sent = 2;
    localparam int cause_tx_error = 1;
    localparam int cause_rx_error = 0;
    localparam logic [1:0] choice_none = 2'h0;
    localparam logic [1:0] choice_external = 2'h1;

    typedef enum logic [1:0] {
        route_none = 2'b00,
        route_external = 2'b01,
        route_internal = 2'b10
    } route_type;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_type;

    typedef struct packed {
        logic tx_event;
        logic tx_sent;
        logic tx_error;
        logic rx_error;
        logic rx_fifo_not_empty;
        logic wait_timeout;
    } uart_event_type;

    typedef struct packed {
        logic card_event;
        logic supply_timer;
    } slot_event_type;
endpackage

// ===== src/line_sampler.sv
// Two-stage synchroniser with edge detection for a pin from outside.
`timescale 1ns/1ps
module line_sampler (
    input wire logic clk,
    input wire logic srst,
    input wire logic pin,
    output logic level,
    output logic rise,
    output logic fall
);
    logic meta_ff;
    logic sync_ff;
    logic last_ff;

    always_ff @(posedge clk) begin
        if (srst) begin
            meta_ff <= 1'b1;
            sync_ff <= 1'b1;
            last_ff <= 1'b1;
        end else begin
            meta_ff <= pin;
            sync_ff <= meta_ff;
            last_ff <= sync_ff;
        end
    end

    assign level = sync_ff;
    assign rise = sync_ff & ~last_ff;
    assign fall = ~sync_ff & last_ff;
endmodule

// ===== src/card_select.sv
// Card interface select, line bypass and interrupt cause register bank.
`timescale 1ns/1ps
// Behaviour
// R1: Choice 00 routes the UART nowhere, 01 to the external interface, 1X to the internal slot.
// R2: Writing the choice only routes the UART and never powers or activates a card.
// R3: With bypass set the UART is cut off and the line follows the line control bits.
// R4: Reading the cause register clears the bits it returns, and it resets to 0x00. The code keeps the receive available bit (bit 4) set on a read.
// R5: Each cause has an enable bit and only enabled causes raise the interrupt.
// R6: Causes are collected only from the interface that is currently chosen.
// R7: Firmware does all error recovery after reading causes; the block only flags.
// R8: Firmware inserts a sync start bit by clearing, stopping clock high, selecting TX, reloading, driving low, restarting.
// R9: Unused bits of the select register read as zero and ignore writes.
// R10: In sync mode the top cause is set when the falling-edge length counter hits its loaded value.
// R11: A disabled cause is still set by its event but raises no interrupt.
// R12: The receive available cause ignores reads and clears only when the receive FIFO is empty.
module card_select (
    input wire logic clk,
    input wire logic srst,
    input wire card_select_pkg::reg_req_type req,
    output logic [7:0] rdata,
    output logic card_irq,
    input wire logic sync_mode,
    input wire card_select_pkg::uart_event_type int_uart_evt,
    input wire card_select_pkg::uart_event_type ext_uart_evt,
    input wire card_select_pkg::slot_event_type int_slot_evt,
    input wire card_select_pkg::slot_event_type ext_slot_evt,
    input wire logic uart_tx_data,
    input wire logic uart_tx_oe_n,
    output logic uart_rx_data,
    input wire logic int_card_clk,
    input wire logic int_io_in,
    output logic int_io_out,
    output logic int_io_oe_n,
    input wire logic ext_card_clk,
    input wire logic ext_card_line_in,
    output logic ext_card_line_out,
    output logic ext_card_line_oe_n
);
    logic [7:0] interface_select_reg_ff;
    logic [7:0] irq_cause_reg_ff;
    logic [7:0] irq_enable_reg_ff;
    logic [7:0] internal_line_ctl_ff;
    logic [7:0] external_line_ctl_ff;
    logic [7:0] length_load_ff;
    logic [7:0] length_count_ff;
    logic length_armed_ff;
    logic [7:0] nxt_cause;
    logic [7:0] nxt_rdata;
    logic [7:0] rdata_ff;
    logic card_irq_ff;
    logic int_io_out_ff;
    logic int_io_oe_n_ff;
    logic ext_out_ff;
    logic ext_oe_n_ff;
    logic uart_rx_ff;
    logic int_clk_fall;
    logic int_io_lvl;
    logic int_io_fall;
    logic ext_clk_fall;
    logic ext_io_lvl;
    logic ext_io_fall;
    logic sel_clk_fall;
    logic sel_clk_rise;
    logic int_clk_rise;
    logic ext_clk_rise;
    logic sel_io_lvl;
    logic sel_io_fall;
    logic bypass;
    logic length_hit;
    card_select_pkg::route_type route;
    card_select_pkg::uart_event_type sel_uart;
    card_select_pkg::slot_event_type sel_slot;

    // Decodes the two choice bits into a route.
    function automatic card_select_pkg::route_type decode_route(
        input logic [7:0] sel
    );
        logic [1:0] c;
        c = sel[card_select_pkg::choice_lsb +: 2];
        if (c[1]) begin
            decode_route = card_select_pkg::route_internal;
        end else if (c == card_select_pkg::choice_external) begin
            decode_route = card_select_pkg::route_external;
        end else begin
            decode_route = card_select_pkg::route_none;
        end
    endfunction

    // Register read or write hit at a given address.
    function automatic logic hit(
        input card_select_pkg::reg_req_type r,
        input logic [15:0] a
    );
        hit = r.addr == a;
    endfunction

    line_sampler int_clk_sync (
        .clk(clk), .srst(srst), .pin(int_card_clk),
        .level(), .rise(int_clk_rise), .fall(int_clk_fall)
    );
    line_sampler int_io_sync (
        .clk(clk), .srst(srst), .pin(int_io_in),
        .level(int_io_lvl), .rise(), .fall(int_io_fall)
    );
    line_sampler ext_clk_sync (
        .clk(clk), .srst(srst), .pin(ext_card_clk),
        .level(), .rise(ext_clk_rise), .fall(ext_clk_fall)
    );
    line_sampler ext_io_sync (
        .clk(clk), .srst(srst), .pin(ext_card_line_in),
        .level(ext_io_lvl), .rise(), .fall(ext_io_fall)
    );

    assign route = decode_route(interface_select_reg_ff); // R1
    assign bypass = interface_select_reg_ff[card_select_pkg::bypass_bit];

    // Selects the event and pin sources of the chosen interface.
    always_comb begin
        sel_uart = '0;
        sel_slot = '0;
        sel_clk_fall = 1'b0;
        sel_clk_rise = 1'b0;
        sel_io_lvl = 1'b1;
        sel_io_fall = 1'b0;
        unique case (route)
            card_select_pkg::route_internal: begin
                sel_uart = int_uart_evt; // R6
                sel_slot = int_slot_evt; // R6
                sel_clk_fall = int_clk_fall;
                sel_clk_rise = int_clk_rise;
                sel_io_lvl = int_io_lvl;
                sel_io_fall = int_io_fall;
            end
            card_select_pkg::route_external: begin
                sel_uart = ext_uart_evt; // R6
                sel_slot = ext_slot_evt; // R6
                sel_clk_fall = ext_clk_fall;
                sel_clk_rise = ext_clk_rise;
                sel_io_lvl = ext_io_lvl;
                sel_io_fall = ext_io_fall;
            end
            card_select_pkg::route_none: begin
                sel_uart = '0;
            end
            default: begin
                sel_uart = '0;
            end
        endcase
    end

    // Select register; only the choice and bypass bits are stored.
    always_ff @(posedge clk) begin
        if (srst) begin
            interface_select_reg_ff <= card_select_pkg::interface_select_reset;
        end else if (req.wr
            && hit(req, card_select_pkg::interface_select_reg_addr)) begin
            interface_select_reg_ff <= req.wdata
                & card_select_pkg::interface_select_mask; // R9
        end
    end

    // Enable register.
    always_ff @(posedge clk) begin
        if (srst) begin
            irq_enable_reg_ff <= card_select_pkg::irq_enable_reset;
        end else if (req.wr
            && hit(req, card_select_pkg::irq_enable_reg_addr)) begin
            irq_enable_reg_ff <= req.wdata;
        end
    end

    // Line control registers; the sample bit reflects the line at card clock rise.
    always_ff @(posedge clk) begin
        if (srst) begin
            internal_line_ctl_ff <= card_select_pkg::line_ctl_reset;
            external_line_ctl_ff <= card_select_pkg::line_ctl_reset;
        end else begin
            if (req.wr && hit(req, card_select_pkg::internal_line_ctl_addr)) begin
                internal_line_ctl_ff <= req.wdata;
            end else if (int_clk_rise) begin
                internal_line_ctl_ff[card_select_pkg::line_sample_bit] <=
                    int_io_lvl; // R3
            end
            if (req.wr && hit(req, card_select_pkg::external_line_ctl_addr)) begin
                external_line_ctl_ff <= req.wdata;
            end else if (ext_clk_rise) begin
                external_line_ctl_ff[card_select_pkg::line_sample_bit] <=
                    ext_io_lvl; // R3
            end
        end
    end

    // Bit length counter on falling card clock edges of the chosen interface.
    always_ff @(posedge clk) begin
        if (srst) begin
            length_load_ff <= card_select_pkg::length_reset;
            length_count_ff <= card_select_pkg::length_reset;
            length_armed_ff <= 1'b0;
        end else if (req.wr
            && hit(req, card_select_pkg::length_count_addr)) begin
            length_load_ff <= req.wdata;
            length_count_ff <= card_select_pkg::length_reset;
            length_armed_ff <= req.wdata != 8'h00;
        end else if (length_armed_ff && sync_mode && sel_clk_fall) begin
            length_count_ff <= length_count_ff + 8'h01; // R10
            if (length_count_ff + 8'h01 == length_load_ff) begin
                length_armed_ff <= 1'b0; // R10
            end
        end
    end

    assign length_hit = length_armed_ff && sync_mode && sel_clk_fall
        && (length_count_ff + 8'h01 == length_load_ff);

    // Cause bits: events set, a read clears all but the receive available bit, a set in the same cycle wins.
    always_comb begin
        nxt_cause = irq_cause_reg_ff;
        if (req.rd && hit(req, card_select_pkg::irq_cause_reg_addr)) begin
            nxt_cause = irq_cause_reg_ff
                & (8'h01 << card_select_pkg::cause_rx_available); // R4 R12
        end
        if (sync_mode ? length_hit : sel_uart.wait_timeout) begin
            nxt_cause[card_select_pkg::cause_length] = 1'b1; // R10 R11
        end
        if (sel_slot.card_event) begin
            nxt_cause[card_select_pkg::cause_card_event] = 1'b1; // R11
        end
        if (sel_slot.supply_timer) begin
            nxt_cause[card_select_pkg::cause_supply_timer] = 1'b1;
        end
        if (sel_uart.tx_event) begin
            nxt_cause[card_select_pkg::cause_tx_event] = 1'b1;
        end
        if (sel_uart.tx_sent) begin
            nxt_cause[card_select_pkg::cause_tx_sent] = 1'b1;
        end
        if (sel_uart.tx_error) begin
            nxt_cause[card_select_pkg::cause_tx_error] = 1'b1; // R7
        end
        if (sel_uart.rx_error) begin
            nxt_cause[card_select_pkg::cause_rx_error] = 1'b1; // R7
        end
        if (bypass) begin
            if (sel_io_fall) begin
                nxt_cause[card_select_pkg::cause_rx_available] = 1'b1;
            end
        end else begin
            nxt_cause[card_select_pkg::cause_rx_available] =
                sel_uart.rx_fifo_not_empty; // R12
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            irq_cause_reg_ff <= card_select_pkg::irq_cause_reset; // R4
        end else begin
            irq_cause_reg_ff <= nxt_cause;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            card_irq_ff <= 1'b0;
        end else begin
            card_irq_ff <= |(nxt_cause & irq_enable_reg_ff); // R5 R11
        end
    end

    // Read data, one cycle after the strobe; unmapped addresses read zero.
    always_comb begin
        nxt_rdata = 8'h00;
        if (req.rd) begin
            unique case (req.addr)
                card_select_pkg::interface_select_reg_addr:
                    nxt_rdata = interface_select_reg_ff; // R9
                card_select_pkg::irq_cause_reg_addr:
                    nxt_rdata = irq_cause_reg_ff; // R4
                card_select_pkg::irq_enable_reg_addr:
                    nxt_rdata = irq_enable_reg_ff;
                card_select_pkg::internal_line_ctl_addr:
                    nxt_rdata = internal_line_ctl_ff;
                card_select_pkg::external_line_ctl_addr:
                    nxt_rdata = external_line_ctl_ff;
                card_select_pkg::length_count_addr:
                    nxt_rdata = length_count_ff;
                card_select_pkg::status_addr:
                    nxt_rdata = {6'h00, length_armed_ff, sel_io_lvl};
                default:
                    nxt_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            rdata_ff <= 8'h00;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    // Line routing; nothing here touches card power or activation.
    always_ff @(posedge clk) begin
        if (srst) begin
            int_io_out_ff <= 1'b1;
            int_io_oe_n_ff <= 1'b1;
            ext_out_ff <= 1'b1;
            ext_oe_n_ff <= 1'b1;
            uart_rx_ff <= 1'b1;
        end else begin
            int_io_out_ff <= 1'b1;
            int_io_oe_n_ff <= 1'b1;
            ext_out_ff <= 1'b1;
            ext_oe_n_ff <= 1'b1;
            uart_rx_ff <= bypass ? 1'b1 : sel_io_lvl; // R3
            if (route == card_select_pkg::route_internal) begin // R1 R2
                int_io_out_ff <= bypass
                    ? internal_line_ctl_ff[card_select_pkg::line_data_bit]
                    : uart_tx_data; // R3
                int_io_oe_n_ff <= bypass
                    ? ~internal_line_ctl_ff[card_select_pkg::line_dir_bit]
                    : uart_tx_oe_n; // R3
            end
            if (route == card_select_pkg::route_external) begin // R1 R2
                ext_out_ff <= bypass
                    ? external_line_ctl_ff[card_select_pkg::line_data_bit]
                    : uart_tx_data; // R3
                ext_oe_n_ff <= bypass
                    ? ~external_line_ctl_ff[card_select_pkg::line_dir_bit]
                    : uart_tx_oe_n; // R3
            end
        end
    end

    assign rdata = rdata_ff;
    assign card_irq = card_irq_ff;
    assign int_io_out = int_io_out_ff;
    assign int_io_oe_n = int_io_oe_n_ff;
    assign ext_card_line_out = ext_out_ff;
    assign ext_card_line_oe_n = ext_oe_n_ff;
    assign uart_rx_data = uart_rx_ff;
endmodule

// ===== tb/card_select_asserts.sv
// Checker that watches the ports of the card select register bank.
`timescale 1ns/1ps
module card_select_asserts (
    input wire logic clk,
    input wire logic srst,
    input wire card_select_pkg::reg_req_type req,
    input wire logic [7:0] rdata,
    input wire logic card_irq,
    input wire logic uart_tx_oe_n,
    input wire logic uart_rx_data,
    input wire logic int_io_out,
    input wire logic int_io_oe_n,
    input wire logic ext_card_line_oe_n,
    input wire card_select_pkg::uart_event_type int_uart_evt,
    input wire card_select_pkg::uart_event_type ext_uart_evt,
    input wire card_select_pkg::slot_event_type int_slot_evt,
    input wire card_select_pkg::slot_event_type ext_slot_evt
);
    localparam logic [15:0] sel_a = card_select_pkg::interface_select_reg_addr;
    localparam logic [15:0] cau_a = card_select_pkg::irq_cause_reg_addr;
    localparam logic [15:0] ena_a = card_select_pkg::irq_enable_reg_addr;
    localparam logic [15:0] lin_a = card_select_pkg::internal_line_ctl_addr;
    logic [7:0] sel_ff;
    logic [7:0] en_ff;
    logic [7:0] lc_ff;
    logic [2:0] age_ff;
    logic quiet;
    logic old;
    logic rd_cau;
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    assign quiet = !(|{int_uart_evt[5:2], ext_uart_evt[5:2], int_slot_evt,
        ext_slot_evt});
    assign old = age_ff[2];
    assign rd_cau = req.rd && req.addr == cau_a;
    // Mirrors of the written registers and the cycles since the last select or line control write.
    always_ff @(posedge clk) begin
        if (srst) begin
            sel_ff <= 8'h00;
            en_ff <= 8'h00;
            lc_ff <= 8'h00;
            age_ff <= 3'h0;
        end else begin
            if (!old) begin
                age_ff <= age_ff + 3'h1;
            end
            if (req.wr && (req.addr == sel_a || req.addr == lin_a)) begin
                age_ff <= 3'h0;
            end
            if (req.wr && req.addr == sel_a) begin
                sel_ff <= req.wdata & card_select_pkg::interface_select_mask;
            end
            if (req.wr && req.addr == lin_a) begin
                lc_ff <= req.wdata;
            end
            if (req.wr && req.addr == ena_a) begin
                en_ff <= req.wdata;
            end
        end
    end
    property p_rdata_idle;
        !$past(req.rd) |-> rdata == 8'h00;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("rdata idle");
    property p_sel_zero;
        $past(req.rd && req.addr == sel_a) |-> rdata[7:4] == 4'h0 && !rdata[0];
    endproperty
    a_sel_zero: assert property (p_sel_zero) else $error("select pad");
    property p_cause_clear;
        $past(quiet) && quiet && rd_cau ##1 quiet && rd_cau
            |=> (rdata & 8'h6f) == 8'h00;
    endproperty
    a_cause_clear: assert property (p_cause_clear) else $error("no clear");
    property p_irq_masked;
        en_ff == 8'h00 && $past(en_ff) == 8'h00 |-> !card_irq;
    endproperty
    a_irq_masked: assert property (p_irq_masked) else $error("masked irq");
    property p_none;
        old && sel_ff[3:2] == 2'h0 |->
            int_io_oe_n && ext_card_line_oe_n && uart_rx_data;
    endproperty
    a_none: assert property (p_none) else $error("none routed");
    property p_ext;
        old && sel_ff[3:2] == 2'h1 && !sel_ff[1] |-> int_io_oe_n;
    endproperty
    a_ext: assert property (p_ext) else $error("external routed");
    property p_int;
        old && sel_ff[3] && !sel_ff[1] && $stable(uart_tx_oe_n)
            && uart_tx_oe_n == $past(uart_tx_oe_n, 2)
            |-> ext_card_line_oe_n && int_io_oe_n == uart_tx_oe_n;
    endproperty
    a_int: assert property (p_int) else $error("internal routed");
    property p_byp_off;
        old && sel_ff[3] && sel_ff[1] && !lc_ff[1] |-> int_io_oe_n;
    endproperty
    a_byp_off: assert property (p_byp_off) else $error("bypass idle");
    property p_byp_on;
        old && sel_ff[3] && sel_ff[1] && lc_ff[1]
            |-> !int_io_oe_n && int_io_out == lc_ff[0];
    endproperty
    a_byp_on: assert property (p_byp_on) else $error("bypass drive");
    c_irq: cover property ($rose(card_irq));
    c_byp: cover property (old && sel_ff[1] && !int_io_oe_n);
    c_two: cover property (rd_cau ##1 rd_cau);
endmodule

// ===== tb/card_model.sv
// Card model with a framed card clock and a pulled-up card line.
`timescale 1ns/1ps
module card_model (
    input wire logic drv_out,
    input wire logic drv_oe_n,
    output logic card_clk,
    output logic line
);
    logic pull_low;
    initial begin
        card_clk = 1'b1;
        pull_low = 1'b0;
    end
    // The line is pulled up and either side may hold it low.
    assign line = ((!drv_oe_n && !drv_out) || pull_low) ? 1'b0 : 1'b1;
    // The clock stops at high level between frames.
    task automatic run(input int n);
        #7;
        repeat (n) begin
            #160 card_clk = 1'b0;
            #160 card_clk = 1'b1;
        end
    endtask
endmodule

// ===== tb/testbench.sv
// Testbench for the card select register bank.
`timescale 1ns/1ps
module testbench;
    localparam logic [15:0] sel_a = card_select_pkg::interface_select_reg_addr;
    localparam logic [15:0] cau_a = card_select_pkg::irq_cause_reg_addr;
    localparam logic [15:0] ena_a = card_select_pkg::irq_enable_reg_addr;
    localparam logic [15:0] lin_a = card_select_pkg::internal_line_ctl_addr;
    localparam logic [15:0] len_a = card_select_pkg::length_count_addr;
    logic clk;
    logic srst;
    card_select_pkg::reg_req_type req;
    card_select_pkg::uart_event_type int_uart_evt;
    card_select_pkg::uart_event_type ext_uart_evt;
    card_select_pkg::slot_event_type int_slot_evt;
    card_select_pkg::slot_event_type ext_slot_evt;
    logic [7:0] rdata;
    logic [7:0] d;
    logic [7:0] e;
    logic card_irq, sync_mode, uart_tx_data, uart_tx_oe_n, uart_rx_data;
    logic int_card_clk, int_io_in, int_io_out, int_io_oe_n;
    logic ext_card_clk, ext_card_line_in, ext_card_line_out, ext_card_line_oe_n;
    int error_cnt;
    int checks;
    card_select DUT (.clk(clk), .srst(srst), .req(req), .rdata(rdata),
        .card_irq(card_irq), .sync_mode(sync_mode),
        .int_uart_evt(int_uart_evt), .ext_uart_evt(ext_uart_evt),
        .int_slot_evt(int_slot_evt), .ext_slot_evt(ext_slot_evt),
        .uart_tx_data(uart_tx_data), .uart_tx_oe_n(uart_tx_oe_n),
        .uart_rx_data(uart_rx_data), .int_card_clk(int_card_clk),
        .int_io_in(int_io_in), .int_io_out(int_io_out),
        .int_io_oe_n(int_io_oe_n), .ext_card_clk(ext_card_clk),
        .ext_card_line_in(ext_card_line_in),
        .ext_card_line_out(ext_card_line_out),
        .ext_card_line_oe_n(ext_card_line_oe_n));
    card_model int_card (.drv_out(int_io_out), .drv_oe_n(int_io_oe_n),
        .card_clk(int_card_clk), .line(int_io_in));
    card_model ext_card (.drv_out(ext_card_line_out),
        .drv_oe_n(ext_card_line_oe_n), .card_clk(ext_card_clk),
        .line(ext_card_line_in));
    always #20 clk = ~clk;
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] v);
        @(posedge clk);
        req.addr <= a;
        req.wdata <= v;
        req.wr <= 1'b1;
        @(posedge clk);
        req.wr <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, output logic [7:0] v);
        @(posedge clk);
        req.addr <= a;
        req.rd <= 1'b1;
        @(posedge clk);
        req.rd <= 1'b0;
        #1 v = rdata;
    endtask
    task automatic rd_twice(output logic [7:0] v1, output logic [7:0] v2);
        @(posedge clk);
        req.addr <= cau_a;
        req.rd <= 1'b1;
        @(posedge clk);
        #1 v1 = rdata;
        @(posedge clk);
        req.rd <= 1'b0;
        #1 v2 = rdata;
    endtask
    task automatic pulse(input logic [5:0] u, input logic [5:0] x,
        input logic [1:0] s, input logic [1:0] t);
        @(posedge clk);
        int_uart_evt <= card_select_pkg::uart_event_type'(u);
        ext_uart_evt <= card_select_pkg::uart_event_type'(x);
        int_slot_evt <= card_select_pkg::slot_event_type'(s);
        ext_slot_evt <= card_select_pkg::slot_event_type'(t);
        @(posedge clk);
        int_uart_evt <= card_select_pkg::uart_event_type'({4'h0, u[1], 1'b0});
        ext_uart_evt <= card_select_pkg::uart_event_type'(6'h00);
        int_slot_evt <= card_select_pkg::slot_event_type'(2'h0);
        ext_slot_evt <= card_select_pkg::slot_event_type'(2'h0);
        idle(2);
    endtask
    task automatic t_reset;
        rd(sel_a, d);
        check(d, 8'h00);
        rd(cau_a, d);
        check(d, 8'h00);
        rd(ena_a, d);
        check(d, 8'h00);
        rd(16'hfe20, d);
        check(d, 8'h00);
        check(card_irq, 1'b0);
        $display("reset test done");
    endtask
    task automatic t_route;
        wr(sel_a, 8'hff);
        rd(sel_a, d);
        check(d, 8'h0e);
        @(posedge clk);
        uart_tx_oe_n <= 1'b0;
        uart_tx_data <= 1'b0;
        for (int c = 0; c < 4; c++) begin
            wr(sel_a, {4'h0, c[1:0], 2'h0});
            idle(4);
            check(int_io_oe_n, c[1] ? 1'b0 : 1'b1);
            check(ext_card_line_oe_n, c == 1 ? 1'b0 : 1'b1);
            check(ext_card_line_out, c == 1 ? 1'b0 : 1'b1);
        end
        @(posedge clk);
        uart_tx_oe_n <= 1'b1;
        int_card.pull_low <= 1'b1;
        idle(6);
        check(uart_rx_data, 1'b0);
        int_card.pull_low <= 1'b0;
        wr(sel_a, 8'h0a);
        wr(lin_a, 8'h02);
        idle(4);
        check(int_io_oe_n, 1'b0);
        check(int_io_out, 1'b0);
        check(uart_rx_data, 1'b1);
        rd(cau_a, d);
        check(d, 8'h10);
        wr(lin_a, 8'h00);
        idle(4);
        check(int_io_oe_n, 1'b1);
        wr(sel_a, 8'h08);
        rd(cau_a, d);
        check(d, 8'h00);
        $display("route test done");
    endtask
    task automatic t_cause;
        pulse(6'h3d, 6'h3d, 2'h3, 2'h3);
        check(card_irq, 1'b0);
        rd_twice(d, e);
        check(d, 8'hef);
        check(e, 8'h00);
        pulse(6'h00, 6'h3d, 2'h0, 2'h3);
        rd(cau_a, d);
        check(d, 8'h00);
        wr(ena_a, 8'h04);
        pulse(6'h08, 6'h00, 2'h0, 2'h0);
        check(card_irq, 1'b0);
        pulse(6'h10, 6'h00, 2'h0, 2'h0);
        check(card_irq, 1'b1);
        rd(cau_a, d);
        check(d, 8'h06);
        check(card_irq, 1'b0);
        wr(ena_a, 8'h10);
        pulse(6'h02, 6'h00, 2'h0, 2'h0);
        check(card_irq, 1'b1);
        rd_twice(d, e);
        check(d, 8'h10);
        check(e, 8'h10);
        pulse(6'h00, 6'h00, 2'h0, 2'h0);
        rd(cau_a, d);
        check(d, 8'h00);
        check(card_irq, 1'b0);
        $display("cause test done");
    endtask
    task automatic t_sync;
        @(posedge clk);
        sync_mode <= 1'b1;
        wr(len_a, 8'h03);
        int_card.run(2);
        idle(6);
        rd(cau_a, d);
        check(d, 8'h00);
        int_card.run(1);
        idle(6);
        rd(cau_a, d);
        check(d, 8'h80);
        wr(len_a, 8'h01);
        int_card.run(1);
        idle(6);
        rd(cau_a, d);
        check(d, 8'h80);
        $display("sync test done");
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        #400000;
        error_cnt++;
        wrap_up;
    end
    initial begin
        clk = 1'b0;
        srst = 1'b1;
        req = '0;
        sync_mode = 1'b0;
        int_uart_evt = '0;
        ext_uart_evt = '0;
        int_slot_evt = '0;
        ext_slot_evt = '0;
        uart_tx_data = 1'b1;
        uart_tx_oe_n = 1'b1;
        error_cnt = 0;
        checks = 0;
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        t_reset;
        t_route;
        t_cause;
        t_sync;
        wrap_up;
    end
endmodule
bind card_select card_select_asserts chk (.clk(clk), .srst(srst), .req(req),
    .rdata(rdata), .card_irq(card_irq), .uart_tx_oe_n(uart_tx_oe_n),
    .uart_rx_data(uart_rx_data), .int_io_out(int_io_out),
    .int_io_oe_n(int_io_oe_n), .ext_card_line_oe_n(ext_card_line_oe_n),
    .int_uart_evt(int_uart_evt), .ext_uart_evt(ext_uart_evt),
    .int_slot_evt(int_slot_evt), .ext_slot_evt(ext_slot_evt));
